/* rtl/bank_cmd_pkg.sv */
// constants and types for the two-bank command state machine
`default_nettype none
package bank_cmd_pkg;
   localparam int unsigned CLK_MHZ = 50;
   // times in ns as printed defaults, converted to cycles (rounded up)
   localparam int unsigned T_RP_NS = 20;
   localparam int unsigned T_RCD_NS = 20;
   localparam int unsigned T_WR_NS = 20;
   localparam int unsigned T_DAL_NS = 40;
   localparam int unsigned T_RC_NS = 70;
   localparam int unsigned T_MCD_NS = 40;
   localparam int unsigned RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DAL_CYC = (T_DAL_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RC_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned MCD_CYC = (T_MCD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned TW = 4;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned BANK_BIT = 11;
   localparam int unsigned AP_BIT = 10;
   localparam int unsigned COL_W = 8;
   localparam int unsigned ROW_W = 11;
   // mode code: burst length field, full page = 3'b111
   localparam logic [2:0] BL_FULL_PAGE = 3'h7;
   localparam int unsigned BL_LSB = 0;
   localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
   localparam logic [8:0] FULL_PAGE_LEN = 9'h100;

   // {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      nop_cmd = 4'h7,
      burst_stop_cmd = 4'h6,
      read_cmd = 4'h5,
      write_cmd = 4'h4,
      row_activate_cmd = 4'h3,
      precharge_cmd = 4'h2,
      refresh_cmd = 4'h1,
      mode_register_load_cmd = 4'h0,
      deselect_cmd = 4'h8
   } cmd_t;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
   } cmd_bus_t;

   typedef enum logic [8:0] {
      st_idle = 9'h001,
      st_row_wait = 9'h002,
      st_active = 9'h004,
      st_write = 9'h008,
      st_write_ap = 9'h010,
      st_wr_rec = 9'h020,
      st_wr_rec_ap = 9'h040,
      st_precharge = 9'h080,
      st_read = 9'h100
   } bank_st_t;

   typedef enum logic [3:0] {
      dev_normal = 4'h1,
      dev_refresh = 4'h2,
      dev_mode = 4'h4,
      dev_self_refresh = 4'h8
   } dev_st_t;
endpackage
`default_nettype wire

/* rtl/bank_cmd_fsm.sv */
// two-bank command decoder and per-bank state machine
`default_nettype none
module bank_cmd_fsm (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // command pins
   input wire logic cke,
   input wire bank_cmd_pkg::cmd_bus_t cmd_in,
   // burst end indication from the data path, one per bank
   input wire logic [1:0] burst_done,
   // state outputs
   output logic [1:0] bank_idle,
   output logic [1:0] bank_active,
   output logic illegal_cmd,
   output logic [bank_cmd_pkg::ADDR_W-1:0] mode_code_q,
   output logic [bank_cmd_pkg::ROW_W-1:0] refresh_row_q,
   output logic [bank_cmd_pkg::COL_W-1:0] column_q,
   output logic self_refresh
);
   bank_cmd_pkg::cmd_t cmd;
   logic tgt;
   logic both_idle;
   logic full_page;
   bank_cmd_pkg::dev_st_t dev_q;
   logic [bank_cmd_pkg::TW-1:0] dev_cnt_q;
   logic [1:0] bad;
   logic dev_bad;

   // decode sampled pins; deselect whenever select is high
   function automatic bank_cmd_pkg::cmd_t decode(input bank_cmd_pkg::cmd_bus_t c);
      if (c.cs_n) begin
         decode = bank_cmd_pkg::deselect_cmd;
      end else begin
         decode = bank_cmd_pkg::cmd_t'({1'b0, c.ras_n, c.cas_n, c.we_n});
      end
   endfunction

   function automatic logic is_nop(input bank_cmd_pkg::cmd_t c);
      is_nop = (c == bank_cmd_pkg::deselect_cmd) || (c == bank_cmd_pkg::nop_cmd)
         || (c == bank_cmd_pkg::burst_stop_cmd);
   endfunction

   // self-refresh ignores all pins but cke
   assign cmd = (dev_q == bank_cmd_pkg::dev_self_refresh || !cke)
      ? bank_cmd_pkg::deselect_cmd : decode(cmd_in);
   assign tgt = cmd_in.addr[bank_cmd_pkg::BANK_BIT];
   assign both_idle = &bank_idle;
   assign full_page = (mode_code_q[bank_cmd_pkg::BL_LSB +: 3] == bank_cmd_pkg::BL_FULL_PAGE);
   assign self_refresh = (dev_q == bank_cmd_pkg::dev_self_refresh);

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bank
         bank_cmd_pkg::bank_st_t st_q;
         logic [bank_cmd_pkg::TW-1:0] cnt_q;
         logic [8:0] burst_q;
         logic ap_q;
         logic mine;
         logic dev_free;
         assign mine = (tgt == b[0]);
         assign dev_free = (dev_q == bank_cmd_pkg::dev_normal);
         assign bank_idle[b] = (st_q == bank_cmd_pkg::st_idle);
         assign bank_active[b] = (st_q == bank_cmd_pkg::st_active);

         // illegal commands for this bank; commands to the other bank pass
         always_comb begin
            bad[b] = 1'b0;
            if (dev_free && mine) begin
               unique case (st_q)
                  bank_cmd_pkg::st_idle:
                     bad[b] = (cmd == bank_cmd_pkg::read_cmd) || (cmd == bank_cmd_pkg::write_cmd);
                  bank_cmd_pkg::st_active, bank_cmd_pkg::st_read, bank_cmd_pkg::st_write:
                     bad[b] = (cmd == bank_cmd_pkg::row_activate_cmd);
                  bank_cmd_pkg::st_wr_rec:
                     bad[b] = (cmd == bank_cmd_pkg::row_activate_cmd)
                        || (cmd == bank_cmd_pkg::precharge_cmd);
                  bank_cmd_pkg::st_row_wait:
                     bad[b] = !is_nop(cmd) && (cmd != bank_cmd_pkg::refresh_cmd)
                        && (cmd != bank_cmd_pkg::mode_register_load_cmd);
                  bank_cmd_pkg::st_precharge:
                     bad[b] = (cmd == bank_cmd_pkg::read_cmd) || (cmd == bank_cmd_pkg::write_cmd)
                        || (cmd == bank_cmd_pkg::row_activate_cmd);
                  bank_cmd_pkg::st_write_ap, bank_cmd_pkg::st_wr_rec_ap:
                     bad[b] = !is_nop(cmd) && (cmd != bank_cmd_pkg::refresh_cmd)
                        && (cmd != bank_cmd_pkg::mode_register_load_cmd)
                        && !(st_q == bank_cmd_pkg::st_write_ap
                        && cmd == bank_cmd_pkg::burst_stop_cmd);
                  default: bad[b] = 1'b0;
               endcase
               if (st_q == bank_cmd_pkg::st_write_ap && cmd == bank_cmd_pkg::burst_stop_cmd) begin
                  bad[b] = 1'b1;
               end
            end
         end

         // bank state; timers count down the documented intervals
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               st_q <= bank_cmd_pkg::st_idle;
               cnt_q <= '0;
               ap_q <= 1'b0;
            end else if (!bad[b] && !dev_bad) begin
               if (cnt_q != '0) begin
                  cnt_q <= cnt_q - 1'b1;
               end
               unique case (st_q)
                  bank_cmd_pkg::st_idle:
                     if (dev_free && mine && cmd == bank_cmd_pkg::row_activate_cmd) begin
                        st_q <= bank_cmd_pkg::st_row_wait;
                        cnt_q <= bank_cmd_pkg::TW'(bank_cmd_pkg::RCD_CYC - 1);
                     end
                  bank_cmd_pkg::st_row_wait:
                     if (cnt_q == '0) begin
                        st_q <= bank_cmd_pkg::st_active;
                     end
                  bank_cmd_pkg::st_active, bank_cmd_pkg::st_read, bank_cmd_pkg::st_write,
                  bank_cmd_pkg::st_wr_rec: begin
                     if (st_q == bank_cmd_pkg::st_wr_rec && cnt_q == '0) begin
                        st_q <= bank_cmd_pkg::st_active;
                     end
                     if (st_q == bank_cmd_pkg::st_write && burst_done[b]) begin
                        st_q <= bank_cmd_pkg::st_wr_rec;
                        cnt_q <= bank_cmd_pkg::TW'(bank_cmd_pkg::WR_CYC - 1);
                     end
                     // read burst end: auto-precharge goes straight to precharge
                     if (st_q == bank_cmd_pkg::st_read && burst_done[b]) begin
                        st_q <= ap_q ? bank_cmd_pkg::st_precharge : bank_cmd_pkg::st_active;
                        cnt_q <= bank_cmd_pkg::TW'(bank_cmd_pkg::RP_CYC - 1);
                     end
                     if (st_q != bank_cmd_pkg::st_active && cmd == bank_cmd_pkg::burst_stop_cmd
                         && full_page) begin
                        st_q <= bank_cmd_pkg::st_active;
                     end
                     if (mine && (cmd == bank_cmd_pkg::read_cmd
                         || cmd == bank_cmd_pkg::write_cmd)) begin
                        // auto-precharge read ends straight in precharge
                        if (cmd == bank_cmd_pkg::write_cmd) begin
                           st_q <= cmd_in.addr[bank_cmd_pkg::AP_BIT]
                              ? bank_cmd_pkg::st_write_ap : bank_cmd_pkg::st_write;
                        end else begin
                           st_q <= bank_cmd_pkg::st_read;
                           ap_q <= cmd_in.addr[bank_cmd_pkg::AP_BIT];
                        end
                     end
                     if (mine && cmd == bank_cmd_pkg::precharge_cmd) begin
                        st_q <= bank_cmd_pkg::st_precharge;
                        cnt_q <= bank_cmd_pkg::TW'(bank_cmd_pkg::RP_CYC - 1);
                     end
                     if (!mine && cmd == bank_cmd_pkg::precharge_cmd
                         && cmd_in.addr[bank_cmd_pkg::AP_BIT]) begin
                        st_q <= bank_cmd_pkg::st_precharge; // all-bank precharge
                        cnt_q <= bank_cmd_pkg::TW'(bank_cmd_pkg::RP_CYC - 1);
                     end
                  end
                  bank_cmd_pkg::st_write_ap:
                     if (burst_done[b]) begin
                        st_q <= bank_cmd_pkg::st_wr_rec_ap;
                        cnt_q <= bank_cmd_pkg::TW'(bank_cmd_pkg::DAL_CYC - 1);
                     end
                  bank_cmd_pkg::st_wr_rec_ap:
                     if (cnt_q == '0) begin
                        st_q <= bank_cmd_pkg::st_idle;
                     end
                  bank_cmd_pkg::st_precharge:
                     if (cnt_q == '0) begin
                        st_q <= bank_cmd_pkg::st_idle;
                     end
                  default: st_q <= bank_cmd_pkg::st_idle;
               endcase
            end
         end
      end
   endgenerate

   // refresh and mode load need both banks idle; all else illegal meanwhile
   assign dev_bad = (dev_q == bank_cmd_pkg::dev_refresh || dev_q == bank_cmd_pkg::dev_mode)
      ? !is_nop(cmd)
      : ((cmd == bank_cmd_pkg::refresh_cmd || cmd == bank_cmd_pkg::mode_register_load_cmd)
         && !both_idle);
   assign illegal_cmd = |bad || dev_bad;

   // device-wide refresh, mode-load and self-refresh state
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dev_q <= bank_cmd_pkg::dev_normal;
         dev_cnt_q <= '0;
         mode_code_q <= bank_cmd_pkg::MODE_RESET;
         refresh_row_q <= '0;
      end else begin
         if (dev_cnt_q != '0) begin
            dev_cnt_q <= dev_cnt_q - 1'b1;
         end
         unique case (dev_q)
            bank_cmd_pkg::dev_normal:
               if (!dev_bad && cmd_in.cs_n == 1'b0 && both_idle
                   && decode(cmd_in) == bank_cmd_pkg::refresh_cmd) begin
                  // internal row counter, address pins ignored
                  refresh_row_q <= refresh_row_q + 1'b1;
                  dev_q <= cke ? bank_cmd_pkg::dev_refresh : bank_cmd_pkg::dev_self_refresh;
                  dev_cnt_q <= bank_cmd_pkg::TW'(bank_cmd_pkg::RC_CYC - 1);
               end else if (!dev_bad && cmd == bank_cmd_pkg::mode_register_load_cmd) begin
                  mode_code_q <= cmd_in.addr;
                  dev_q <= bank_cmd_pkg::dev_mode;
                  dev_cnt_q <= bank_cmd_pkg::TW'(bank_cmd_pkg::MCD_CYC - 1);
               end
            bank_cmd_pkg::dev_refresh, bank_cmd_pkg::dev_mode:
               if (dev_cnt_q == '0) begin
                  dev_q <= bank_cmd_pkg::dev_normal;
               end
            bank_cmd_pkg::dev_self_refresh:
               if (cke) begin
                  dev_q <= bank_cmd_pkg::dev_normal;
               end
            default: dev_q <= bank_cmd_pkg::dev_normal;
         endcase
      end
   end

   // column taken from low eight bits; a8 and a9 dropped
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         column_q <= '0;
      end else if (!illegal_cmd
                   && (cmd == bank_cmd_pkg::read_cmd || cmd == bank_cmd_pkg::write_cmd)) begin
         column_q <= cmd_in.addr[bank_cmd_pkg::COL_W-1:0];
      end
   end
endmodule
`default_nettype wire

/* bench/bank_cmd_checker_assertions.sv */
// assertion checker for the two-bank command state machine
`default_nettype none
module bank_cmd_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // command side
   input wire logic cke,
   input wire bank_cmd_pkg::cmd_bus_t cmd_in,
   input wire logic [1:0] burst_done,
   // state side
   input wire logic [1:0] bank_idle,
   input wire logic [1:0] bank_active,
   input wire logic illegal_cmd,
   input wire logic [bank_cmd_pkg::ADDR_W-1:0] mode_code_q,
   input wire logic [bank_cmd_pkg::ROW_W-1:0] refresh_row_q,
   input wire logic [bank_cmd_pkg::COL_W-1:0] column_q,
   input wire logic self_refresh
);
   logic [3:0] code;
   logic take;
   logic b;
   // deselect wins over whatever the strobes show
   assign code = cmd_in.cs_n ? 4'h8 : {1'b0, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
   assign take = cke && !self_refresh && !illegal_cmd;
   assign b = cmd_in.addr[11];
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   AST_MODE_CAPTURE: assert property (
      take && code == bank_cmd_pkg::mode_register_load_cmd |=> mode_code_q == $past(cmd_in.addr))
      else $error("mode code not captured");
   AST_ACT_TO_ROW: assert property (
      take && code == bank_cmd_pkg::row_activate_cmd && !b |-> ##[1:3] bank_active[0])
      else $error("activated bank never became active");
   AST_ACT_WAIT_READ: assert property (
      take && code == bank_cmd_pkg::row_activate_cmd && !b
      |=> (code == bank_cmd_pkg::read_cmd && !b && cke |-> illegal_cmd))
      else $error("read accepted during activate delay");
   AST_PRE_WAIT_READ: assert property (
      take && code == bank_cmd_pkg::precharge_cmd && bank_active[b]
      |=> (code == bank_cmd_pkg::read_cmd && b == $past(b) && cke |-> illegal_cmd))
      else $error("read accepted during row precharge");
   AST_REF_BLOCKS: assert property (
      take && code == bank_cmd_pkg::refresh_cmd
      |=> (code == bank_cmd_pkg::row_activate_cmd && cke |-> illegal_cmd))
      else $error("activate accepted during refresh");
   AST_MODE_BLOCKS: assert property (
      take && code == bank_cmd_pkg::mode_register_load_cmd
      |=> (code == bank_cmd_pkg::row_activate_cmd && cke |-> illegal_cmd))
      else $error("activate accepted during mode delay");
   AST_REFUSED_NO_CHANGE: assert property (
      illegal_cmd && cke && !self_refresh |=> $stable(mode_code_q) && $stable(column_q))
      else $error("refused command changed state");
   AST_COLUMN: assert property (
      take && (code == bank_cmd_pkg::read_cmd || code == bank_cmd_pkg::write_cmd)
      |=> column_q == $past(cmd_in.addr[7:0]))
      else $error("column not captured");
   AST_REF_ROW: assert property (
      take && code == bank_cmd_pkg::refresh_cmd |-> ##[1:5] $changed(refresh_row_q))
      else $error("refresh row counter did not move");
   AST_SELF_HOLD: assert property (
      self_refresh && !cke |=> $stable(mode_code_q) && bank_idle == 2'h3)
      else $error("input acted on during self refresh");
   // main scenarios reached
   cover property (take && code == bank_cmd_pkg::mode_register_load_cmd);
   cover property (take && code == bank_cmd_pkg::refresh_cmd);
   cover property ($rose(self_refresh));
   cover property (burst_done[0] && !bank_active[0]);
endmodule
bind bank_cmd_fsm bank_cmd_checker chk (.mclk(mclk), .arst_n(arst_n), .cke(cke),
   .cmd_in(cmd_in), .burst_done(burst_done), .bank_idle(bank_idle),
   .bank_active(bank_active), .illegal_cmd(illegal_cmd), .mode_code_q(mode_code_q),
   .refresh_row_q(refresh_row_q), .column_q(column_q), .self_refresh(self_refresh));
`default_nettype wire

/* bench/ctrl_model.sv */
// controller-side command pin model for the bank state machine
`default_nettype none
module ctrl_model (
   // requested command
   input wire bank_cmd_pkg::cmd_t op,
   input wire logic [bank_cmd_pkg::ADDR_W-1:0] op_addr,
   // pins toward the device
   output var bank_cmd_pkg::cmd_bus_t cmd_in
);
   // strobe levels straight from the code caller pads waits with nops
   // and idles both banks before refresh or mode load
   assign cmd_in = {op, op_addr};
endmodule
`default_nettype wire

/* bench/sdram_bank_command_fsm_test.sv */
// self-checking bench for the two-bank command state machine
`default_nettype none
module sdram_bank_command_fsm_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int sel; logic [11:0] exp;} note_t;
   logic mclk, arst_n, cke, illegal_cmd, self_refresh;
   logic [1:0] burst_done, bank_idle, bank_active;
   logic [11:0] mode_code_q, op_addr, r, m;
   logic [10:0] refresh_row_q;
   logic [7:0] column_q;
   bank_cmd_pkg::cmd_t op;
   bank_cmd_pkg::cmd_bus_t cmd_in;
   note_t notes[$];
   int errors, check_count;
   string names[7] = '{"illegal_cmd", "bank_idle", "bank_active", "mode_code_q", "column_q",
      "self_refresh", "refresh_row_q"};
   ctrl_model ctrl (.op(op), .op_addr(op_addr), .cmd_in(cmd_in));
   bank_cmd_fsm uut (.mclk(mclk), .arst_n(arst_n), .cke(cke), .cmd_in(cmd_in),
      .burst_done(burst_done), .bank_idle(bank_idle), .bank_active(bank_active),
      .illegal_cmd(illegal_cmd), .mode_code_q(mode_code_q), .refresh_row_q(refresh_row_q),
      .column_q(column_q), .self_refresh(self_refresh));
   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end
   // command presented 2 ns after the edge, held for the whole cycle
   task automatic issue(bank_cmd_pkg::cmd_t c, logic [11:0] a);
      @(posedge mclk);
      #2;
      op = c;
      op_addr = a;
   endtask
   task automatic expect_at(int sel, logic [11:0] e);
      notes.push_back('{sel, e});
   endtask
   // alternate deselect and nop, address flipped so stale pins never look valid
   task automatic idle_cycles(int n);
      for (int i = 0; i < n; i++) issue(i[0] ? bank_cmd_pkg::nop_cmd : bank_cmd_pkg::deselect_cmd, ~op_addr);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // compare at mid-cycle, where the combinational flag has settled
   always @(negedge mclk) begin
      note_t n;
      logic [11:0] seen;
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n.sel)
            0: seen = {11'h000, illegal_cmd};
            1: seen = {10'h000, bank_idle};
            2: seen = {10'h000, bank_active};
            3: seen = mode_code_q;
            4: seen = {4'h0, column_q};
            5: seen = {11'h000, self_refresh};
            default: seen = {1'h0, refresh_row_q};
         endcase
         check_count++;
         if (seen !== n.exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", names[n.sel], n.exp, seen);
         end
      end
   end
   initial begin
      #100000;
      errors++;
      finish_test();
   end
   initial begin
      arst_n = 0;
      cke = 1;
      burst_done = 2'h0;
      op = bank_cmd_pkg::deselect_cmd;
      op_addr = 12'h000;
      errors = 0;
      check_count = 0;
      void'($urandom(27065));
      repeat (12) @(posedge mclk);
      #2 arst_n = 1;
      expect_at(1, 12'h003);
      expect_at(3, 12'h000);
      // mode load, then activate inside the mode delay
      m = 12'($urandom());
      issue(bank_cmd_pkg::mode_register_load_cmd, m);
      issue(bank_cmd_pkg::row_activate_cmd, 12'h000); expect_at(0, 12'h001);
      idle_cycles(3); expect_at(3, m);
      // refresh blocks activate of the other bank, stop acts as nop
      issue(bank_cmd_pkg::refresh_cmd, ~m);
      issue(bank_cmd_pkg::row_activate_cmd, 12'h800); expect_at(0, 12'h001);
      issue(bank_cmd_pkg::burst_stop_cmd, m); expect_at(0, 12'h000);
      idle_cycles(4); expect_at(1, 12'h003);
      expect_at(6, 12'h001);
      // activate bank 0, read refused inside the activate delay
      issue(bank_cmd_pkg::row_activate_cmd, 12'h000);
      issue(bank_cmd_pkg::read_cmd, 12'h000); expect_at(0, 12'h001);
      idle_cycles(2); expect_at(2, 12'h001);
      // write with auto-precharge, other bank activated meanwhile
      issue(bank_cmd_pkg::write_cmd, 12'h400);
      issue(bank_cmd_pkg::read_cmd, 12'h000); expect_at(0, 12'h001);
      issue(bank_cmd_pkg::row_activate_cmd, 12'h800); expect_at(0, 12'h000);
      burst_done = 2'h1;
      issue(bank_cmd_pkg::row_activate_cmd, 12'h000); expect_at(0, 12'h001);
      burst_done = 2'h0;
      idle_cycles(3); expect_at(1, 12'h001);
      // bank 1 write, recovery, read start, column with bits 8 and 9 ignored
      issue(bank_cmd_pkg::write_cmd, 12'h800);
      issue(bank_cmd_pkg::nop_cmd, ~m);
      burst_done = 2'h2;
      r = 12'($urandom());
      issue(bank_cmd_pkg::read_cmd, {2'h2, r[9:0]}); expect_at(0, 12'h000);
      burst_done = 2'h0;
      issue(bank_cmd_pkg::nop_cmd, ~r); expect_at(4, {4'h0, r[7:0]});
      burst_done = 2'h2;
      // precharge bank 1, read refused, idle after the precharge time
      issue(bank_cmd_pkg::precharge_cmd, 12'h800);
      burst_done = 2'h0;
      issue(bank_cmd_pkg::read_cmd, 12'h800); expect_at(0, 12'h001);
      idle_cycles(2); expect_at(1, 12'h003);
      expect_at(4, {4'h0, r[7:0]});
      // read with auto-precharge on bank 1 ends in precharge, not row active
      issue(bank_cmd_pkg::row_activate_cmd, 12'h800);
      idle_cycles(1);
      issue(bank_cmd_pkg::read_cmd, 12'hc00);
      issue(bank_cmd_pkg::nop_cmd, r);
      burst_done = 2'h2;
      issue(bank_cmd_pkg::nop_cmd, ~r);
      burst_done = 2'h0;
      expect_at(2, 12'h000);
      // self refresh ignores a mode load
      issue(bank_cmd_pkg::refresh_cmd, r);
      cke = 0;
      issue(bank_cmd_pkg::mode_register_load_cmd, ~m); expect_at(5, 12'h001);
      issue(bank_cmd_pkg::nop_cmd, r);
      cke = 1;
      idle_cycles(3); expect_at(3, m);
      @(negedge mclk);
      finish_test();
   end
endmodule
`default_nettype wire
